/* design/asp_device.sv */
// Converter end: serial port, conversion timing, limit registers and window alerts.
// Assumes link pins are synchronous to clock and slow against it (several cycles per level).
// Functional notes
// [R1] Lower bound: nine bits over 000
// [R2] Upper bound: nine bits over 111
// [R3] Rearm margin: nine bits over 000
// [R4] Bits 15..9 unused, read as zero
// [R5] Reset: lower zeros, upper and margin ones
// [R6] Output driven only while frame selected
// [R7] Both clock idle levels supported
// [R8] Clock ignored while frame deselected
// [R9] Start falling edge: hold, 600 ns conversion
// [R10] Host ends start pulse, reads after conversion; one CTRL write setting CTRL_FRAME and CTRL_CONV reads during the conversion
// [R11] Result sent 16 bits, MSB first
// [R12] Last bit after fifteenth falling edge
// [R13] Host waits 1 us between starts
// [R14] Write: address, write bit, data
// [R15] Read: address, bit ten zero
// [R16] Read data returned in following frame
// [R17] Pending conversion result overrides read data
// [R18] Alert when outside lower or upper bound
// [R19] Alert register clears on second clock
// [R20] Frame end reinitialises counter and shifter
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
module asp_device
   import asp_pkg::*;
(
   // System
   input wire logic clock,
   input wire logic rst,
   // Link
   asp_link_if.dev link,
   // Analog front end
   input wire logic [11:0] sample_data,
   input wire logic [2:0] sample_channel,
   output logic hold,
   output logic shared_alert_output
);
   logic cs_q, sclk_q, cv_q;
   logic [15:0] shift_out_q, shift_out_d;
   logic [15:0] shift_in_q, shift_in_d;
   logic [4:0] rise_cnt_q, rise_cnt_d;
   logic sdo_q, sdo_d, sdo_oe_q, sdo_oe_d;
   logic frame_alert_q, frame_alert_d;
   logic rd_pend_q, rd_pend_d;
   logic [4:0] rd_addr_q, rd_addr_d;
   logic converting_q, converting_d, hold_q, hold_d;
   logic [7:0] conv_cnt_q, conv_cnt_d;
   logic [11:0] held_data_q, held_data_d;
   logic [2:0] held_ch_q, held_ch_d;
   logic [15:0] result_q, result_d;
   logic conv_pend_q, conv_pend_d;
   logic [8:0] lower_q [NUM_CH];
   logic [8:0] lower_d [NUM_CH];
   logic [8:0] upper_q [NUM_CH];
   logic [8:0] upper_d [NUM_CH];
   logic [8:0] margin_q [NUM_CH];
   logic [8:0] margin_d [NUM_CH];
   logic [15:0] alert_bits_q, alert_bits_d;
   logic alert_q, alert_d;

   logic cs_fall, cs_rise, sclk_rise, sclk_fall, conv_fall;
   logic cmd_exec, alert_clr, conv_done;
   logic [4:0] cmd_addr;

   assign cs_fall = cs_q & ~link.cs_n;
   assign cs_rise = ~cs_q & link.cs_n;
   // Clock edges count only inside a frame that has already been opened. [R8]
   assign sclk_rise = ~cs_q & ~link.cs_n & ~sclk_q & link.sclk;
   assign sclk_fall = ~cs_q & ~link.cs_n & sclk_q & ~link.sclk;
   assign conv_fall = cv_q & ~link.conversion_start_n;
   assign cmd_exec = cs_rise && (rise_cnt_q == FRAME_BITS);
   assign cmd_addr = shift_in_q[CMD_ADDR_MSB:CMD_ADDR_LSB];
   assign alert_clr = frame_alert_q && sclk_rise && (rise_cnt_q == 5'h01); // [R19]
   assign conv_done = converting_q && (conv_cnt_q == 8'(CONV_CYCLES - 1));

   function automatic logic [15:0] reg_value(input logic [4:0] addr);
      logic [4:0] idx;
      logic [2:0] ch;
      logic [4:0] sel;
      idx = addr - ADDR_LOWER_BASE;
      ch = 3'(idx / ADDR_STRIDE);
      sel = idx % ADDR_STRIDE;
      reg_value = 16'h0000;
      if (addr == ADDR_RESULT)
      begin
         reg_value = result_q;
      end
      else if (addr == ADDR_ALERT)
      begin
         reg_value = alert_bits_q;
      end
      else if (addr >= ADDR_LOWER_BASE)
      begin
         // Unused upper bits always read as zero. [R4]
         unique case (sel)
            5'h00: reg_value = {BOUND_UNUSED, lower_q[ch]};
            5'h01: reg_value = {BOUND_UNUSED, upper_q[ch]};
            default: reg_value = {BOUND_UNUSED, margin_q[ch]};
         endcase
      end
   endfunction : reg_value

   // Serial frame engine.
   always_comb
   begin
      logic [15:0] word;
      word = 16'h0000;
      shift_out_d = shift_out_q;
      shift_in_d = shift_in_q;
      rise_cnt_d = rise_cnt_q;
      sdo_d = sdo_q;
      sdo_oe_d = sdo_oe_q;
      frame_alert_d = frame_alert_q;
      rd_pend_d = rd_pend_q;
      rd_addr_d = rd_addr_q;
      if (cs_fall)
      begin
         // A finished conversion beats a pending register read. [R17] [R16]
         if (conv_pend_q)
         begin
            word = result_q;
         end
         else if (rd_pend_q)
         begin
            word = reg_value(rd_addr_q);
         end
         frame_alert_d = !conv_pend_q && rd_pend_q && (rd_addr_q == ADDR_ALERT);
         shift_out_d = word;
         sdo_d = word[15]; // [R11]
         sdo_oe_d = 1'b1; // [R6]
         rise_cnt_d = 5'h00;
      end
      if (sclk_rise)
      begin
         shift_in_d = {shift_in_q[14:0], link.sdi};
         if (rise_cnt_q != 5'h1f)
         begin
            rise_cnt_d = rise_cnt_q + 5'h01;
         end
      end
      // A falling edge before the first rising one is the idle-high lead-in. [R7] [R12]
      if (sclk_fall && (rise_cnt_q != 5'h00) && (rise_cnt_q < FRAME_BITS))
      begin
         shift_out_d = {shift_out_q[14:0], 1'b0};
         sdo_d = shift_out_q[14]; // [R11]
      end
      if (cs_rise)
      begin
         sdo_oe_d = 1'b0; // [R6]
         sdo_d = 1'b0;
         rise_cnt_d = 5'h00; // [R20]
         shift_in_d = 16'h0000; // [R20]
         frame_alert_d = 1'b0;
         if (cmd_exec)
         begin
            // Only whole 16-bit frames are commands; a read waits for the next frame. [R15]
            rd_pend_d = !shift_in_q[CMD_WRITE_BIT];
            rd_addr_d = cmd_addr;
         end
      end
   end

   // Conversion timing, limit registers and alerts.
   always_comb
   begin
      logic [11:0] lo12, hi12, m12;
      logic [12:0] sum;
      logic [4:0] idx;
      lo12 = 12'h000;
      hi12 = 12'h000;
      m12 = 12'h000;
      sum = 13'h0000;
      idx = 5'h00;
      converting_d = converting_q;
      hold_d = hold_q;
      conv_cnt_d = conv_cnt_q;
      held_data_d = held_data_q;
      held_ch_d = held_ch_q;
      result_d = result_q;
      conv_pend_d = conv_pend_q;
      lower_d = lower_q;
      upper_d = upper_q;
      margin_d = margin_q;
      alert_bits_d = alert_bits_q;
      if (conv_fall && !converting_q)
      begin
         converting_d = 1'b1; // [R9]
         hold_d = 1'b1;
         conv_cnt_d = 8'h00;
         held_data_d = sample_data;
         held_ch_d = sample_channel;
      end
      else if (converting_q)
      begin
         conv_cnt_d = conv_cnt_q + 8'h01;
      end
      if (cs_fall && conv_pend_q)
      begin
         conv_pend_d = 1'b0;
      end
      if (cmd_exec && shift_in_q[CMD_WRITE_BIT] && (cmd_addr >= ADDR_LOWER_BASE))
      begin
         // Only the low nine data bits are stored. [R14] [R4]
         idx = cmd_addr - ADDR_LOWER_BASE;
         unique case (idx % ADDR_STRIDE)
            5'h00: lower_d[3'(idx / ADDR_STRIDE)] = shift_in_q[8:0];
            5'h01: upper_d[3'(idx / ADDR_STRIDE)] = shift_in_q[8:0];
            default: margin_d[3'(idx / ADDR_STRIDE)] = shift_in_q[8:0];
         endcase
      end
      if (alert_clr)
      begin
         alert_bits_d = 16'h0000; // [R19]
      end
      if (conv_done)
      begin
         converting_d = 1'b0; // [R9]
         hold_d = 1'b0;
         conv_pend_d = 1'b1;
         lo12 = {lower_q[held_ch_q], LOWER_PAD}; // [R1]
         hi12 = {upper_q[held_ch_q], UPPER_PAD}; // [R2]
         m12 = {margin_q[held_ch_q], MARGIN_PAD}; // [R3]
         // Automatic release once the result is back inside by the margin.
         sum = {1'b0, held_data_q} + {1'b0, m12};
         if (sum < {1'b0, hi12})
         begin
            alert_bits_d[{held_ch_q, 1'b0}] = 1'b0; // [R3]
         end
         sum = {1'b0, lo12} + {1'b0, m12};
         if ({1'b0, held_data_q} > sum)
         begin
            alert_bits_d[{held_ch_q, 1'b1}] = 1'b0; // [R3]
         end
         // New violations are set last so they win over any clear. [R18]
         if (held_data_q > hi12)
         begin
            alert_bits_d[{held_ch_q, 1'b0}] = 1'b1;
         end
         else if (held_data_q < lo12)
         begin
            alert_bits_d[{held_ch_q, 1'b1}] = 1'b1;
         end
         result_d = {held_ch_q, |alert_bits_d, held_data_q};
      end
      alert_d = |alert_bits_d;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         cs_q <= 1'b1;
         sclk_q <= 1'b0;
         cv_q <= 1'b1;
         shift_out_q <= 16'h0000;
         shift_in_q <= 16'h0000;
         rise_cnt_q <= 5'h00;
         sdo_q <= 1'b0;
         sdo_oe_q <= 1'b0;
         frame_alert_q <= 1'b0;
         rd_pend_q <= 1'b0;
         rd_addr_q <= 5'h00;
         converting_q <= 1'b0;
         hold_q <= 1'b0;
         conv_cnt_q <= 8'h00;
         held_data_q <= 12'h000;
         held_ch_q <= 3'h0;
         result_q <= 16'h0000;
         conv_pend_q <= 1'b0;
         for (int i = 0; i < NUM_CH; i++)
         begin
            lower_q[i] <= LOWER_RST; // [R5]
            upper_q[i] <= UPPER_RST; // [R5]
            margin_q[i] <= MARGIN_RST; // [R5]
         end
         alert_bits_q <= 16'h0000;
         alert_q <= 1'b0;
      end
      else
      begin
         cs_q <= link.cs_n;
         sclk_q <= link.sclk;
         cv_q <= link.conversion_start_n;
         shift_out_q <= shift_out_d;
         shift_in_q <= shift_in_d;
         rise_cnt_q <= rise_cnt_d;
         sdo_q <= sdo_d;
         sdo_oe_q <= sdo_oe_d;
         frame_alert_q <= frame_alert_d;
         rd_pend_q <= rd_pend_d;
         rd_addr_q <= rd_addr_d;
         converting_q <= converting_d;
         hold_q <= hold_d;
         conv_cnt_q <= conv_cnt_d;
         held_data_q <= held_data_d;
         held_ch_q <= held_ch_d;
         result_q <= result_d;
         conv_pend_q <= conv_pend_d;
         lower_q <= lower_d;
         upper_q <= upper_d;
         margin_q <= margin_d;
         alert_bits_q <= alert_bits_d;
         alert_q <= alert_d;
      end
   end

   assign link.sdo = sdo_q;
   assign link.sdo_oe = sdo_oe_q;
   assign hold = hold_q;
   assign shared_alert_output = alert_q;
endmodule : asp_device

/* design/asp_pkg.sv */
// Shared constants for the converter serial port, its limit registers and the host end.
// Assumes a single 250 MHz system clock on both ends.
package asp_pkg;
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned CONV_TIME_NS = 600;
   localparam int unsigned CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned CONV_GAP_NS = 1000;
   localparam int unsigned CONV_GAP_CYCLES = (CONV_GAP_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned CONV_SETTLE_CYCLES = CONV_CYCLES + 4;
   localparam int unsigned CONV_LOW_CYCLES = 10;
   localparam int unsigned SCLK_HALF_CYCLES = 4;
   localparam int unsigned NUM_CH = 8;
   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam logic [5:0] FRAME_EDGES = 6'h20;
   // Command word layout.
   localparam int CMD_ADDR_MSB = 15;
   localparam int CMD_ADDR_LSB = 11;
   localparam int CMD_WRITE_BIT = 10;
   // Device register addresses; bounds of channel n sit at LOWER_BASE + 3n (+1 upper, +2 margin).
   localparam logic [4:0] ADDR_RESULT = 5'h00;
   localparam logic [4:0] ADDR_ALERT = 5'h07;
   localparam logic [4:0] ADDR_LOWER_BASE = 5'h08;
   localparam logic [4:0] ADDR_STRIDE = 5'h03;
   localparam logic [8:0] LOWER_RST = 9'h000;
   localparam logic [8:0] UPPER_RST = 9'h1ff;
   localparam logic [8:0] MARGIN_RST = 9'h1ff;
   localparam logic [2:0] LOWER_PAD = 3'h0;
   localparam logic [2:0] UPPER_PAD = 3'h7;
   localparam logic [2:0] MARGIN_PAD = 3'h0;
   localparam logic [6:0] BOUND_UNUSED = 7'h00;
   // Host APB register map.
   localparam logic [7:0] APB_CTRL = 8'h00;
   localparam logic [7:0] APB_TX = 8'h04;
   localparam logic [7:0] APB_RX = 8'h08;
   localparam logic [7:0] APB_STATUS = 8'h0c;
   localparam int CTRL_FRAME = 0;
   localparam int CTRL_CONV = 1;
   localparam int CTRL_CPOL = 2;
endpackage : asp_pkg

/* design/asp_link_if.sv */
// Serial link between the converter end and the host end.
// Serial output is three-state by its sdo_oe enable; the bench joins sdo straight to the host and never resolves the wire.
`timescale 1ns/1ps
interface asp_link_if;
   logic cs_n;
   logic sclk;
   logic sdi;
   logic conversion_start_n;
   logic sdo;
   logic sdo_oe;
   modport dev (input cs_n, input sclk, input sdi, input conversion_start_n,
      output sdo, output sdo_oe);
   modport host (output cs_n, output sclk, output sdi, output conversion_start_n,
      input sdo, input sdo_oe);
endinterface : asp_link_if

/* design/asp_host.sv */
// Host end: APB-controlled serial controller that runs frames and conversion starts.
// Assumes an APB master on the system clock; the serial clock is a divided output.
`timescale 1ns/1ps
module asp_host
   import asp_pkg::*;
(
   // System
   input wire logic clock,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Link
   asp_link_if.host link
);
   typedef enum logic [1:0] {H_IDLE, H_LEAD, H_SHIFT, H_TRAIL} asp_hstate_t;
   asp_hstate_t state_q, state_d;
   logic [2:0] div_q, div_d;
   logic [5:0] edges_q, edges_d;
   logic [4:0] rises_q, rises_d;
   logic cs_n_q, cs_n_d, sclk_q, sclk_d, sdi_q, sdi_d, cpol_q, cpol_d;
   logic [15:0] tx_q, tx_d, tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d, rx_q, rx_d;
   logic cv_n_q, cv_n_d;
   logic [7:0] cv_cnt_q, cv_cnt_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   logic tick, wr_done, go_frame, go_conv, frame_block;

   assign tick = (div_q == 3'(SCLK_HALF_CYCLES - 1));
   assign wr_done = psel && penable && pready_q && pwrite;
   assign go_frame = wr_done && (paddr == APB_CTRL) && pwdata[CTRL_FRAME];
   assign go_conv = wr_done && (paddr == APB_CTRL) && pwdata[CTRL_CONV];
   // No frame starts while a result is still being converted, except one set in the same CTRL write as its start. [R10]
   assign frame_block = (cv_cnt_q != 8'h00) && (cv_cnt_q < 8'(CONV_SETTLE_CYCLES));

   always_comb
   begin
      state_d = state_q;
      div_d = (state_q == H_IDLE || tick) ? 3'h0 : div_q + 3'h1;
      edges_d = edges_q;
      rises_d = rises_q;
      cs_n_d = cs_n_q;
      sclk_d = sclk_q;
      sdi_d = sdi_q;
      tx_sh_d = tx_sh_q;
      rx_sh_d = rx_sh_q;
      rx_d = rx_q;
      unique case (state_q)
         H_IDLE:
         begin
            sclk_d = cpol_q;
            if (go_frame && !frame_block)
            begin
               cs_n_d = 1'b0;
               tx_sh_d = tx_q;
               sdi_d = tx_q[15];
               edges_d = 6'h00;
               rises_d = 5'h00;
               state_d = H_LEAD;
            end
         end
         H_LEAD:
         begin
            if (tick)
            begin
               state_d = H_SHIFT;
            end
         end
         H_SHIFT:
         begin
            if (tick)
            begin
               sclk_d = !sclk_q;
               edges_d = edges_q + 6'h01;
               if (!sclk_q)
               begin
                  rx_sh_d = {rx_sh_q[14:0], link.sdo};
                  rises_d = rises_q + 5'h01;
               end
               else if ((rises_q != 5'h00) && (rises_q < FRAME_BITS))
               begin
                  sdi_d = tx_sh_q[14];
                  tx_sh_d = {tx_sh_q[14:0], 1'b0};
               end
               if (edges_q == FRAME_EDGES - 6'h01)
               begin
                  state_d = H_TRAIL;
               end
            end
         end
         H_TRAIL:
         begin
            if (tick)
            begin
               cs_n_d = 1'b1; // [R12]
               rx_d = rx_sh_q;
               state_d = H_IDLE;
            end
         end
      endcase
   end

   always_comb
   begin
      cv_n_d = cv_n_q;
      cv_cnt_d = cv_cnt_q;
      if (cv_cnt_q != 8'h00)
      begin
         cv_cnt_d = (cv_cnt_q == 8'(CONV_GAP_CYCLES)) ? 8'h00 : cv_cnt_q + 8'h01; // [R13]
         if (cv_cnt_q == 8'(CONV_LOW_CYCLES))
         begin
            cv_n_d = 1'b1; // [R10]
         end
      end
      else if (go_conv && state_q == H_IDLE)
      begin
         cv_n_d = 1'b0;
         cv_cnt_d = 8'h01;
      end
   end

   always_comb
   begin
      pready_d = psel && penable && !pready_q;
      prdata_d = 32'h0000_0000;
      pslverr_d = 1'b0;
      tx_d = tx_q;
      cpol_d = cpol_q;
      if (pready_d)
      begin
         unique case (paddr)
            APB_CTRL: prdata_d = {29'h0, cpol_q, 2'h0};
            APB_TX: prdata_d = {16'h0000, tx_q};
            APB_RX: prdata_d = {16'h0000, rx_q};
            APB_STATUS: prdata_d = {29'h0, frame_block, cv_cnt_q != 8'h00, state_q != H_IDLE};
            default: pslverr_d = 1'b1;
         endcase
      end
      // Clock polarity changes only between frames so a frame never sees a glitch. [R7]
      if (wr_done && paddr == APB_CTRL && state_q == H_IDLE)
      begin
         cpol_d = pwdata[CTRL_CPOL];
      end
      if (wr_done && paddr == APB_TX)
      begin
         tx_d = pwdata[15:0]; // [R14] [R15] [R16]
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state_q <= H_IDLE;
         div_q <= 3'h0;
         edges_q <= 6'h00;
         rises_q <= 5'h00;
         cs_n_q <= 1'b1;
         sclk_q <= 1'b0;
         sdi_q <= 1'b0;
         cpol_q <= 1'b0;
         tx_q <= 16'h0000;
         tx_sh_q <= 16'h0000;
         rx_sh_q <= 16'h0000;
         rx_q <= 16'h0000;
         cv_n_q <= 1'b1;
         cv_cnt_q <= 8'h00;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         div_q <= div_d;
         edges_q <= edges_d;
         rises_q <= rises_d;
         cs_n_q <= cs_n_d;
         sclk_q <= sclk_d;
         sdi_q <= sdi_d;
         cpol_q <= cpol_d;
         tx_q <= tx_d;
         tx_sh_q <= tx_sh_d;
         rx_sh_q <= rx_sh_d;
         rx_q <= rx_d;
         cv_n_q <= cv_n_d;
         cv_cnt_q <= cv_cnt_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign link.cs_n = cs_n_q;
   assign link.sclk = sclk_q;
   assign link.sdi = sdi_q;
   assign link.conversion_start_n = cv_n_q;
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
endmodule : asp_host

/* test/asp_link_sva.sv */
// Checker for the serial link between the host end and the converter end.
// Assumes every link signal is a flop output on the system clock; sits beside the link.
`timescale 1ns/1ps
module asp_link_sva
   import asp_pkg::*;
(
   // System
   input wire logic clock,
   input wire logic rst,
   // Link
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic conversion_start_n,
   input wire logic sdo,
   input wire logic sdo_oe
);
   logic [9:0] gap_d, gap_q;
   logic [4:0] rise_d, rise_q;
   logic start_q, sclk_q;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   // The gap counter saturates so that a long idle spell never wraps into a false short gap.
   always_comb
   begin
      gap_d = (gap_q == 10'h3ff) ? gap_q : gap_q + 10'h001;
      if (start_q && !conversion_start_n)
         gap_d = 10'h000;
      rise_d = cs_n ? 5'h00 : rise_q + {4'h0, sclk & ~sclk_q};
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         gap_q <= 10'h3ff;
         rise_q <= 5'h00;
         start_q <= 1'b1;
         sclk_q <= 1'b0;
      end
      else
      begin
         gap_q <= gap_d;
         rise_q <= rise_d;
         start_q <= conversion_start_n;
         sclk_q <= sclk;
      end
   end

   chk_oe_idle: assert property (cs_n [*3] |-> !sdo_oe)
      else $error("serial output driven while frame deselected");
   chk_oe_rise: assert property ($fell(cs_n) |-> ##[1:3] sdo_oe)
      else $error("serial output not driven after frame select fell");
   chk_oe_hold: assert property ((!cs_n) [*4] |-> sdo_oe)
      else $error("serial output released inside a frame");
   chk_sclk_ignored: assert property (cs_n [*4] |-> $stable(sdo) && !sdo_oe)
      else $error("serial output moved while frame deselected");
   chk_bit_hold: assert property ($rose(sclk) && !cs_n |-> ##1 $stable(sdo) [*3])
      else $error("serial output changed after a rising serial clock");
   chk_frame_len: assert property ($rose(cs_n) |-> rise_q == 5'h10)
      else $error("frame did not carry sixteen rising clock edges");
   chk_start_pulse: assert property ($fell(conversion_start_n) |->
      ##1 (!conversion_start_n) [*8] ##[1:4] conversion_start_n)
      else $error("start line not returned high during conversion");
   chk_start_gap: assert property ($fell(conversion_start_n) |->
      gap_q + 1 >= CONV_GAP_CYCLES)
      else $error("conversion starts closer than the minimum spacing");
   chk_read_after: assert property ($fell(cs_n) |-> gap_q + 1 > CONV_CYCLES)
      else $error("frame started before conversion finished");
endmodule : asp_link_sva

/* test/adc_serial_port_and_limits_tb.sv */
// Testbench: host end and converter end joined by the link, driven over APB.
// Assumes the host answers every APB access with a one-cycle pready pulse.
`timescale 1ns/1ps
module adc_serial_port_and_limits_tb
   import asp_pkg::*;
;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, hold, shared_alert_output;
   logic [11:0] sample_data = 12'h000;
   logic [2:0] sample_channel = 3'h0;
   logic [31:0] rd;
   logic err;
   logic cpol = 1'b0;
   int fails = 0;
   int check_count = 0;
   logic [8:0] rst_tab [3] = '{LOWER_RST, UPPER_RST, MARGIN_RST};
   logic [11:0] smp [4] = '{12'h800, 12'h807, 12'h808, 12'h7ff};
   logic [15:0] alr [4] = '{16'h0000, 16'h0000, 16'h0010, 16'h0020};

   asp_link_if link();

   asp_device asp_device_i (.clock(clock), .rst(rst), .link(link),
      .sample_data(sample_data), .sample_channel(sample_channel), .hold(hold),
      .shared_alert_output(shared_alert_output));
   asp_host asp_host_i (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link));
   asp_link_sva asp_link_sva_i (.clock(clock), .rst(rst), .cs_n(link.cs_n), .sclk(link.sclk),
      .sdi(link.sdi), .conversion_start_n(link.conversion_start_n), .sdo(link.sdo),
      .sdo_oe(link.sdo_oe));

   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      check("apb answer", {15'h0, pready}, 16'h0001);
      if (pready !== 1'b1)
         end_sim();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Polls status; the status word also covers the conversion spacing window.
   task automatic wait_idle;
      int n;
      n = 0;
      do
      begin
         apb(APB_STATUS, 1'b0, 32'h0);
         n++;
      end
      while (rd[2:0] !== 3'h0 && n < 300);
      if (rd[2:0] !== 3'h0)
      begin
         check("idle wait", {13'h0, rd[2:0]}, 16'h0000);
         end_sim();
      end
   endtask : wait_idle

   task automatic frame(input logic [15:0] w);
      apb(APB_TX, 1'b1, {16'h0, w});
      apb(APB_CTRL, 1'b1, {29'h0, cpol, 2'b01});
      wait_idle();
      apb(APB_RX, 1'b0, 32'h0);
   endtask : frame

   task automatic dev_rd(input logic [4:0] a);
      frame({a, 11'h000});
      frame({ADDR_RESULT, 11'h000});
   endtask : dev_rd

   task automatic conv(input logic [11:0] d, input logic [2:0] ch);
      sample_data <= d;
      sample_channel <= ch;
      apb(APB_CTRL, 1'b1, {29'h0, cpol, 2'b10});
      repeat (2) @(posedge clock);
      check("hold during conversion", {15'h0, hold}, 16'h0001);
      wait_idle();
      check("hold after conversion", {15'h0, hold}, 16'h0000);
   endtask : conv

   function automatic logic [4:0] bound_addr(input int c, input int k);
      return 5'(int'(ADDR_LOWER_BASE) + int'(ADDR_STRIDE) * c + k);
   endfunction : bound_addr

   initial
   begin
      forever #2 clock = ~clock;
   end

   initial
   begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      apb(8'h10, 1'b0, 32'h0);
      check("unmapped error", {15'h0, err}, 16'h0001);
      for (int c = 0; c < 8; c += 7)
         for (int k = 0; k < 3; k++)
         begin
            dev_rd(bound_addr(c, k));
            check("reset value", rd[15:0], {BOUND_UNUSED, rst_tab[k]});
         end
      // Both idle levels; the level switch toggles the clock while deselected.
      for (int p = 0; p < 2; p++)
      begin
         cpol = p[0];
         apb(APB_CTRL, 1'b1, {29'h0, cpol, 2'b00});
         apb(APB_CTRL, 1'b0, 32'h0);
         check("clock level", {15'h0, rd[CTRL_CPOL]}, {15'h0, cpol});
         frame({bound_addr(p, 0), 1'b1, (p == 0) ? 10'h3aa : 10'h255});
         dev_rd(bound_addr(p, 0));
         check("lower write", rd[15:0], (p == 0) ? 16'h01aa : 16'h0055);
      end
      cpol = 1'b0;
      apb(APB_CTRL, 1'b1, 32'h0);
      frame({bound_addr(2, 0), 1'b1, 10'h100});
      frame({bound_addr(2, 1), 1'b1, 10'h100});
      frame({bound_addr(2, 2), 1'b1, 10'h000});
      dev_rd(bound_addr(2, 2));
      check("margin write", rd[15:0], 16'h0000);
      for (int i = 0; i < 4; i++)
      begin
         frame({bound_addr(2, 0), 11'h000});
         conv(smp[i], 3'h2);
         frame(16'h0000);
         check("result word", rd[15:0], {3'h2, |alr[i], smp[i]});
         check("alert pin", {15'h0, shared_alert_output}, {15'h0, |alr[i]});
         dev_rd(ADDR_ALERT);
         check("alert register", rd[15:0], alr[i]);
         dev_rd(ADDR_ALERT);
         check("alert cleared", rd[15:0], 16'h0000);
         check("alert pin cleared", {15'h0, shared_alert_output}, 16'h0000);
      end
      end_sim();
   end
endmodule : adc_serial_port_and_limits_tb
